// ---- rrs_pkg.sv ----
// Shared constants and types for the return, rotate, sleep and subtract unit.
// Assumes a 32-bit AXI4-Lite master and a 16-bit instruction word.
package rrs_pkg;

   // ****************************************
   // Register map (byte addresses)
   // ****************************************
   localparam logic [7:0] OFF_OPCODE = 8'h00;
   localparam logic [7:0] OFF_ACC = 8'h04;
   localparam logic [7:0] OFF_FLAGS = 8'h08;
   localparam logic [7:0] OFF_PC = 8'h0c;
   localparam logic [7:0] OFF_STACK = 8'h10;
   localparam logic [7:0] OFF_SP = 8'h14;
   localparam logic [7:0] OFF_WDT = 8'h18;
   localparam logic [7:0] OFF_FADDR = 8'h1c;
   localparam logic [7:0] OFF_FDATA = 8'h20;
   localparam logic [7:0] OFF_BUSY = 8'h24;

   // ****************************************
   // Field positions and widths
   // ****************************************
   localparam int PC_W = 15;
   localparam int STACK_DEPTH = 16;
   localparam int SP_W = 4;
   localparam int FILE_DEPTH = 128;
   localparam int FADDR_W = 7;
   localparam int DEST_BIT = 9;
   localparam int WDT_PRE_LSB = 8;

   // ****************************************
   // Opcodes
   // ****************************************
   localparam logic [7:0] OPC_RETURN_WITH_LITERAL_HI = 8'h0c;
   localparam logic [7:0] OPC_LITERAL_MINUS_ACCUMULATOR_HI = 8'h0d;
   localparam logic [14:0] OPC_RETURN_HI = 15'h0009;
   localparam logic [5:0] OPC_RLF_HI = 6'h0d;
   localparam logic [5:0] OPC_RRF_HI = 6'h0c;
   localparam logic [15:0] OPC_SLEEP = 16'h0063;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [4:0] FLAGS_RST = 5'h18;
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [PC_W-1:0] PC_RST = 15'h0000;
   localparam logic [15:0] OPCODE_RST = 16'h0000;

   // ****************************************
   // AXI responses
   // ****************************************
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   // ****************************************
   // Types
   // ****************************************
   typedef struct packed {
      logic wdt_expired_flag;
      logic power_down_flag;
      logic zero;
      logic half_carry_flag;
      logic carry;
   } rrs_flags_t;

   typedef enum logic [2:0] {
      ALU_ROT_L = 3'b001,
      ALU_ROT_R = 3'b010,
      ALU_SUB = 3'b100
   } rrs_alu_op_t;

   typedef struct packed {
      logic [7:0] value;
      logic carry;
      logic half_carry;
      logic zero;
   } rrs_alu_out_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_EXEC = 3'b010,
      ST_FLUSH = 3'b100
   } rrs_state_t;

endpackage

// ---- rrs_alu.sv ----
// Rotate-through-carry and literal-minus-accumulator datapath.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module rrs_alu (
   input rrs_pkg::rrs_alu_op_t op,
   input wire logic [7:0] src,
   input wire logic [7:0] lit,
   input wire logic [7:0] acc,
   input wire logic carry_in,
   output rrs_pkg::rrs_alu_out_t res
);
   logic [8:0] diff;
   logic [4:0] low_diff;

   // ****************************************
   // Datapath
   // ****************************************
   // RQ10 two's complement
   assign diff = {1'b0, lit} + {1'b0, ~acc} + 9'h001;
   assign low_diff = {1'b0, lit[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;

   always_comb begin
      res = '0;
      case (op)
         // RQ3 left rotate
         rrs_pkg::ALU_ROT_L: begin
            res.value = {src[6:0], carry_in};
            res.carry = src[7];
         end
         // RQ4 right rotate
         rrs_pkg::ALU_ROT_R: begin
            res.value = {carry_in, src[7:1]};
            res.carry = src[0];
         end
         // RQ9 literal minus accumulator
         default: begin
            res.value = diff[7:0];
            res.carry = diff[8];
            res.half_carry = low_diff[4];
            res.zero = (diff[7:0] == 8'h00);
         end
      endcase
   end
endmodule // rrs_alu

// ---- rrs_exec.sv ----
// Execution unit: return-with-literal, return, rotates, sleep, literal subtract.
// Assumes an AXI4-Lite master issuing one write and one read at a time.
// Contract
// RQ1 - Return-with-literal loads accumulator from literal, PC from stack top; two cycles.
// RQ2 - Return pops the stack into PC in two cycles, flags untouched.
// RQ3 - Left rotate moves bit n to n+1, bit7 to carry, carry to bit0.
// RQ4 - Right rotate moves bit n to n-1, bit0 to carry, carry to bit7.
// RQ5 - Destination bit zero writes accumulator, one writes the file register.
// RQ6 - Rotates address files 0 to 127 and change only carry.
// RQ7 - Sleep clears watchdog counter and its prescaler.
// RQ8 - Sleep clears power-down flag, sets expired flag, nothing else.
// RQ9 - Literal subtract writes literal minus accumulator, updates carry, half carry, zero.
// RQ10 - Carry clear when accumulator exceeds literal; half carry likewise on nibbles.
// RQ11 - Both returns move stack pointer down one entry.
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module rrs_exec (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // ****************************************
   // Declarations
   // ****************************************
   rrs_pkg::rrs_state_t state_q, state_d;
   rrs_pkg::rrs_flags_t flags_q;
   rrs_pkg::rrs_alu_out_t alu_res;
   rrs_pkg::rrs_alu_op_t alu_op;
   logic [15:0] opcode_q;
   logic [7:0] accumulator_q;
   logic [rrs_pkg::PC_W-1:0] program_counter_q;
   logic [rrs_pkg::PC_W-1:0] stack_mem [rrs_pkg::STACK_DEPTH];
   logic [rrs_pkg::SP_W-1:0] sp_q;
   logic [7:0] file_mem [rrs_pkg::FILE_DEPTH];
   logic [rrs_pkg::FADDR_W-1:0] faddr_q;
   logic [7:0] watchdog_counter_q, wdt_prescaler_q;
   logic aw_have_q, w_have_q, bvalid_q, rvalid_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q, rdata_q;
   logic [3:0] wstrb_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rd_word;
   logic rd_hit;

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic is_addr(input logic [7:0] a, input logic [7:0] off);
      return a[7:2] == off[7:2];
   endfunction

   // ****************************************
   // Decode
   // ****************************************
   wire busy = (state_q != rrs_pkg::ST_IDLE);
   wire exec = (state_q == rrs_pkg::ST_EXEC);
   wire [7:0] lit = opcode_q[7:0];
   wire dest_file = opcode_q[rrs_pkg::DEST_BIT];
   wire [rrs_pkg::FADDR_W-1:0] fsel = opcode_q[rrs_pkg::FADDR_W-1:0];
   wire is_return_with_literal = (opcode_q[15:8] == rrs_pkg::OPC_RETURN_WITH_LITERAL_HI);
   wire is_literal_minus_accumulator = (opcode_q[15:8] == rrs_pkg::OPC_LITERAL_MINUS_ACCUMULATOR_HI);
   wire is_return = (opcode_q[15:1] == rrs_pkg::OPC_RETURN_HI);
   wire is_rlf = (opcode_q[15:10] == rrs_pkg::OPC_RLF_HI);
   wire is_rrf = (opcode_q[15:10] == rrs_pkg::OPC_RRF_HI);
   wire is_sleep = (opcode_q == rrs_pkg::OPC_SLEEP);
   wire is_rot = is_rlf | is_rrf;
   wire is_ret = is_return_with_literal | is_return;
   wire [rrs_pkg::SP_W-1:0] sp_top = sp_q - 4'h1;
   wire [rrs_pkg::PC_W-1:0] top_of_stack = stack_mem[sp_top];

   assign alu_op = is_rlf ? rrs_pkg::ALU_ROT_L : (is_rrf ? rrs_pkg::ALU_ROT_R : rrs_pkg::ALU_SUB);

   rrs_alu u_alu (
      .op(alu_op),
      .src(file_mem[fsel]),
      .lit(lit),
      .acc(accumulator_q),
      .carry_in(flags_q.carry),
      .res(alu_res)
   );

   // ****************************************
   // AXI4-Lite write channel
   // ****************************************
   wire aw_take = s_axi_awvalid & s_axi_awready;
   wire w_take = s_axi_wvalid & s_axi_wready;
   wire commit = aw_have_q & w_have_q & ~bvalid_q;
   wire wr_ok = commit & ~busy;
   wire [31:0] wmerged_acc = merge({24'h0, accumulator_q}, wdata_q, wstrb_q);
   wire wr_opc = wr_ok & is_addr(awaddr_q, rrs_pkg::OFF_OPCODE);
   wire wr_acc = wr_ok & is_addr(awaddr_q, rrs_pkg::OFF_ACC);
   wire wr_flg = wr_ok & is_addr(awaddr_q, rrs_pkg::OFF_FLAGS);
   wire wr_pc = wr_ok & is_addr(awaddr_q, rrs_pkg::OFF_PC);
   wire wr_stk = wr_ok & is_addr(awaddr_q, rrs_pkg::OFF_STACK);
   wire wr_sp = wr_ok & is_addr(awaddr_q, rrs_pkg::OFF_SP);
   wire wr_wdt = wr_ok & is_addr(awaddr_q, rrs_pkg::OFF_WDT);
   wire wr_fad = wr_ok & is_addr(awaddr_q, rrs_pkg::OFF_FADDR);
   wire wr_fdt = wr_ok & is_addr(awaddr_q, rrs_pkg::OFF_FDATA);
   wire wr_map = is_addr(awaddr_q, rrs_pkg::OFF_OPCODE) | is_addr(awaddr_q, rrs_pkg::OFF_ACC)
      | is_addr(awaddr_q, rrs_pkg::OFF_FLAGS) | is_addr(awaddr_q, rrs_pkg::OFF_PC)
      | is_addr(awaddr_q, rrs_pkg::OFF_STACK) | is_addr(awaddr_q, rrs_pkg::OFF_SP)
      | is_addr(awaddr_q, rrs_pkg::OFF_WDT) | is_addr(awaddr_q, rrs_pkg::OFF_FADDR)
      | is_addr(awaddr_q, rrs_pkg::OFF_FDATA) | is_addr(awaddr_q, rrs_pkg::OFF_BUSY);
   wire [31:0] wval = merge(32'h0, wdata_q, wstrb_q);

   assign s_axi_awready = ~aw_have_q;
   assign s_axi_wready = ~w_have_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= rrs_pkg::RESP_OKAY;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0;
         wstrb_q <= 4'h0;
      end else begin
         if (aw_take) begin
            aw_have_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (w_take) begin
            w_have_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (commit) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= !wr_map ? rrs_pkg::RESP_DECERR :
                       (busy ? rrs_pkg::RESP_SLVERR : rrs_pkg::RESP_OKAY);
         end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // ****************************************
   // AXI4-Lite read channel
   // ****************************************
   always_comb begin
      rd_word = 32'h0;
      rd_hit = 1'b1;
      if (is_addr(s_axi_araddr, rrs_pkg::OFF_OPCODE)) begin
         rd_word = {16'h0, opcode_q};
      end else if (is_addr(s_axi_araddr, rrs_pkg::OFF_ACC)) begin
         rd_word = {24'h0, accumulator_q};
      end else if (is_addr(s_axi_araddr, rrs_pkg::OFF_FLAGS)) begin
         rd_word = {27'h0, flags_q};
      end else if (is_addr(s_axi_araddr, rrs_pkg::OFF_PC)) begin
         rd_word = {17'h0, program_counter_q};
      end else if (is_addr(s_axi_araddr, rrs_pkg::OFF_STACK)) begin
         rd_word = {17'h0, top_of_stack};
      end else if (is_addr(s_axi_araddr, rrs_pkg::OFF_SP)) begin
         rd_word = {28'h0, sp_q};
      end else if (is_addr(s_axi_araddr, rrs_pkg::OFF_WDT)) begin
         rd_word = {16'h0, wdt_prescaler_q, watchdog_counter_q};
      end else if (is_addr(s_axi_araddr, rrs_pkg::OFF_FADDR)) begin
         rd_word = {25'h0, faddr_q};
      end else if (is_addr(s_axi_araddr, rrs_pkg::OFF_FDATA)) begin
         rd_word = {24'h0, file_mem[faddr_q]};
      end else if (is_addr(s_axi_araddr, rrs_pkg::OFF_BUSY)) begin
         rd_word = {31'h0, busy};
      end else begin
         rd_hit = 1'b0;
      end
   end

   assign s_axi_arready = ~rvalid_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0;
         rresp_q <= rrs_pkg::RESP_OKAY;
      end else if (s_axi_arvalid & s_axi_arready) begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_word;
         rresp_q <= rd_hit ? rrs_pkg::RESP_OKAY : rrs_pkg::RESP_DECERR;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // ****************************************
   // Sequencer
   // ****************************************
   always_comb begin
      state_d = state_q;
      case (state_q)
         rrs_pkg::ST_IDLE: if (wr_opc) state_d = rrs_pkg::ST_EXEC;
         // RQ1 second cycle
         rrs_pkg::ST_EXEC: state_d = is_ret ? rrs_pkg::ST_FLUSH : rrs_pkg::ST_IDLE;
         default: state_d = rrs_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) state_q <= rrs_pkg::ST_IDLE;
      else state_q <= state_d;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) opcode_q <= rrs_pkg::OPCODE_RST;
      else if (wr_opc) opcode_q <= wval[15:0];
   end

   // ****************************************
   // Architectural state
   // ****************************************
   // RQ1 literal to accumulator; RQ5 and RQ9 routing
   always_ff @(posedge aclk) begin
      if (!aresetn) accumulator_q <= rrs_pkg::ACC_RST;
      else if (exec & is_return_with_literal) accumulator_q <= lit;
      else if (exec & (is_literal_minus_accumulator | (is_rot & ~dest_file))) accumulator_q <= alu_res.value;
      else if (wr_acc) accumulator_q <= wmerged_acc[7:0];
   end

   // RQ5 file destination
   always_ff @(posedge aclk) begin
      if (exec & is_rot & dest_file) file_mem[fsel] <= alu_res.value;
      else if (wr_fdt) file_mem[faddr_q] <= wval[7:0];
   end

   // RQ1 RQ2 stack top to counter
   always_ff @(posedge aclk) begin
      if (!aresetn) program_counter_q <= rrs_pkg::PC_RST;
      else if (exec & is_ret) program_counter_q <= top_of_stack;
      else if (exec) program_counter_q <= program_counter_q + 15'h0001;
      else if (wr_pc) program_counter_q <= wval[rrs_pkg::PC_W-1:0];
   end

   // RQ11 pointer moves down
   always_ff @(posedge aclk) begin
      if (!aresetn) sp_q <= '0;
      else if (exec & is_ret) sp_q <= sp_top;
      else if (wr_stk) sp_q <= sp_q + 4'h1;
      else if (wr_sp) sp_q <= wval[rrs_pkg::SP_W-1:0];
   end

   // Overflow wraps; guarding depth is left to the surrounding core
   always_ff @(posedge aclk) begin
      if (wr_stk) stack_mem[sp_q] <= wval[rrs_pkg::PC_W-1:0];
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) faddr_q <= '0;
      else if (wr_fad) faddr_q <= wval[rrs_pkg::FADDR_W-1:0];
   end

   // RQ7 sleep clears watchdog
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         watchdog_counter_q <= 8'h00;
         wdt_prescaler_q <= 8'h00;
      end else if (exec & is_sleep) begin
         watchdog_counter_q <= 8'h00;
         wdt_prescaler_q <= 8'h00;
      end else if (wr_wdt) begin
         watchdog_counter_q <= wval[7:0];
         wdt_prescaler_q <= wval[rrs_pkg::WDT_PRE_LSB +: 8];
      end
   end

   // RQ6 RQ8 RQ9 flag updates
   always_ff @(posedge aclk) begin
      if (!aresetn) flags_q <= rrs_pkg::FLAGS_RST;
      else if (exec & is_rot) flags_q.carry <= alu_res.carry;
      else if (exec & is_literal_minus_accumulator) begin
         flags_q.carry <= alu_res.carry;
         flags_q.half_carry_flag <= alu_res.half_carry;
         flags_q.zero <= alu_res.zero;
      end else if (exec & is_sleep) begin
         flags_q.power_down_flag <= 1'b0;
         flags_q.wdt_expired_flag <= 1'b1;
      end else if (wr_flg) flags_q <= wval[4:0];
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_ret_exec;
      exec & is_ret;
   endsequence
   sequence s_two_cycle;
      (state_q == rrs_pkg::ST_EXEC) ##1 (state_q == rrs_pkg::ST_FLUSH) ##1 !busy;
   endsequence

   property p_return_with_literal;
      exec & is_return_with_literal |=> accumulator_q == $past(lit) && program_counter_q == $past(top_of_stack);
   endproperty
   a_return_with_literal: assert property (p_return_with_literal) else $error("return_with_literal result wrong"); // RQ1
   property p_two_cycle;
      s_ret_exec |-> s_two_cycle;
   endproperty
   a_two_cycle: assert property (p_two_cycle) else $error("return not two cycles"); // RQ2
   property p_return_flags;
      exec & is_return |=> $stable(flags_q) && $stable(accumulator_q);
   endproperty
   a_return_flags: assert property (p_return_flags) else $error("return touched state"); // RQ2
   property p_rlf;
      exec & is_rlf & ~dest_file |=> accumulator_q == {$past(file_mem[fsel][6:0]), $past(flags_q.carry)}
         && flags_q.carry == $past(file_mem[fsel][7]);
   endproperty
   a_rlf: assert property (p_rlf) else $error("left rotate wrong"); // RQ3
   property p_rrf_val;
      exec & is_rrf |-> alu_res.value == {flags_q.carry, file_mem[fsel][7:1]};
   endproperty
   a_rrf_val: assert property (p_rrf_val) else $error("right rotate wrong"); // RQ4
   property p_rrf_carry;
      exec & is_rrf |=> flags_q.carry == $past(file_mem[fsel][0]);
   endproperty
   a_rrf_carry: assert property (p_rrf_carry) else $error("right rotate carry wrong"); // RQ4
   property p_rot_file;
      exec & is_rot & dest_file |=> $stable(accumulator_q)
         && file_mem[$past(fsel)] == $past(alu_res.value);
   endproperty
   a_rot_file: assert property (p_rot_file) else $error("rotate destination wrong"); // RQ5
   property p_rot_flags;
      exec & is_rot |=> flags_q[4:1] == $past(flags_q[4:1]);
   endproperty
   a_rot_flags: assert property (p_rot_flags) else $error("rotate changed other flags"); // RQ6
   property p_sleep_wdt;
      exec & is_sleep |=> watchdog_counter_q == 8'h00 && wdt_prescaler_q == 8'h00;
   endproperty
   a_sleep_wdt: assert property (p_sleep_wdt) else $error("watchdog not cleared"); // RQ7
   property p_sleep_flags;
      exec & is_sleep |=> !flags_q.power_down_flag && flags_q.wdt_expired_flag
         && flags_q[2:0] == $past(flags_q[2:0]);
   endproperty
   a_sleep_flags: assert property (p_sleep_flags) else $error("sleep flags wrong"); // RQ8
   property p_literal_minus_accumulator;
      exec & is_literal_minus_accumulator |=> accumulator_q == 8'($past(lit) - $past(accumulator_q))
         && flags_q.zero == (accumulator_q == 8'h00);
   endproperty
   a_literal_minus_accumulator: assert property (p_literal_minus_accumulator) else $error("subtract result wrong"); // RQ9
   property p_sub_carry;
      exec & is_literal_minus_accumulator |=> flags_q.carry == ($past(accumulator_q) <= $past(lit))
         && flags_q.half_carry_flag == ($past(accumulator_q[3:0]) <= $past(lit[3:0]));
   endproperty
   a_sub_carry: assert property (p_sub_carry) else $error("subtract carry wrong"); // RQ10
   property p_pop;
      exec & is_ret |=> sp_q == $past(sp_q) - 4'h1;
   endproperty
   a_pop: assert property (p_pop) else $error("stack pointer not popped"); // RQ11
endmodule // rrs_exec

// ---- rrs_exec_bench.sv ----
// Self-checking bench for the return, rotate, sleep and subtract unit.
// Assumes rrs_exec with its AXI4-Lite slave and the register map of rrs_pkg.
`timescale 1ns/1ps
module rrs_exec_bench;

   // ****************************************
   // Signals
   // ****************************************
   logic aclk, aresetn;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   int n_fail;
   int samples_checked;
   logic [31:0] rd;
   logic [1:0] rr;
   logic [14:0] pc_exp;
   logic [8:0] r9;
   logic [15:0] rop [4] = '{16'h357f, 16'h367f, 16'h307f, 16'h3200};
   logic [7:0] rdat [4] = '{8'he6, 8'h5a, 8'hcd, 8'h02};
   logic [4:0] rflg [4] = '{5'h1e, 5'h07, 5'h19, 5'h05};
   logic [7:0] sacc [6] = '{8'h05, 8'h03, 8'h10, 8'h0f, 8'h00, 8'hff};
   logic [7:0] slit [6] = '{8'h03, 8'h05, 8'h10, 8'h10, 8'hff, 8'h00};

   rrs_exec u_dut (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready)
   );

   // ****************************************
   // Clock and watchdog
   // ****************************************
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end

   // Whole run is a few hundred cycles; generous margin
   initial begin
      repeat (20000) @(posedge aclk);
      n_fail++;
      stop_test;
   end

   // ****************************************
   // Tasks
   // ****************************************
   task automatic stop_test;
      if (n_fail == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Address and data offered together, each dropped at its own handshake
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) begin
            s_axi_bready <= 1'b0;
            chk({30'h0, s_axi_bresp}, {30'h0, er});
            break;
         end
      end
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      d = 32'hdead_beef;
      r = 2'h1;
      forever begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) begin
            s_axi_rready <= 1'b0;
            d = s_axi_rdata;
            r = s_axi_rresp;
            break;
         end
      end
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      axi_rd(a, rd, rr);
      chk(rd, exp);
   endtask

   // Busy is polled, never assumed gone after a fixed time
   task automatic exec(input logic [15:0] op);
      axi_wr(rrs_pkg::OFF_OPCODE, {16'h0, op}, rrs_pkg::RESP_OKAY);
      forever begin
         axi_rd(rrs_pkg::OFF_BUSY, rd, rr);
         if (rd[0] === 1'b0) break;
      end
   endtask

   function automatic logic [8:0] rot(input logic left, input logic [7:0] v, input logic c);
      return left ? {v[7], v[6:0], c} : {v[0], c, v[7:1]};
   endfunction

   function automatic logic [31:0] sub_flags(input logic [7:0] a, input logic [7:0] k);
      logic [7:0] r;
      r = k - a;
      return {27'h0, 2'b10, (r == 8'h00), (a[3:0] <= k[3:0]), (a <= k)};
   endfunction

   // ****************************************
   // Tests
   // ****************************************
   initial begin
      n_fail = 0;
      samples_checked = 0;
      aresetn = 1'b0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hf;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      rd_chk(rrs_pkg::OFF_FLAGS, 32'h18);
      rd_chk(rrs_pkg::OFF_SP, 32'h0);
      // Two pushes, then both kinds of return
      axi_wr(rrs_pkg::OFF_PC, 32'h0100, rrs_pkg::RESP_OKAY);
      axi_wr(rrs_pkg::OFF_STACK, 32'h1111, rrs_pkg::RESP_OKAY);
      axi_wr(rrs_pkg::OFF_STACK, 32'h2222, rrs_pkg::RESP_OKAY);
      axi_wr(rrs_pkg::OFF_FLAGS, 32'h0a, rrs_pkg::RESP_OKAY);
      exec(16'h0c5a);
      rd_chk(rrs_pkg::OFF_ACC, 32'h5a);
      rd_chk(rrs_pkg::OFF_PC, 32'h2222);
      rd_chk(rrs_pkg::OFF_SP, 32'h1);
      rd_chk(rrs_pkg::OFF_STACK, 32'h1111);
      rd_chk(rrs_pkg::OFF_FLAGS, 32'h0a);
      exec(16'h0013);
      rd_chk(rrs_pkg::OFF_PC, 32'h1111);
      rd_chk(rrs_pkg::OFF_SP, 32'h0);
      rd_chk(rrs_pkg::OFF_ACC, 32'h5a);
      rd_chk(rrs_pkg::OFF_FLAGS, 32'h0a);
      axi_wr(rrs_pkg::OFF_STACK, 32'h0777, rrs_pkg::RESP_OKAY);
      exec(16'h0012);
      rd_chk(rrs_pkg::OFF_PC, 32'h0777);
      pc_exp = 15'h0777;
      // Rotates: both directions, both destinations, files 0 and 127
      for (int i = 0; i < 4; i++) begin
         axi_wr(rrs_pkg::OFF_FADDR, {25'h0, rop[i][6:0]}, rrs_pkg::RESP_OKAY);
         axi_wr(rrs_pkg::OFF_FDATA, {24'h0, rdat[i]}, rrs_pkg::RESP_OKAY);
         axi_wr(rrs_pkg::OFF_ACC, 32'h33, rrs_pkg::RESP_OKAY);
         axi_wr(rrs_pkg::OFF_FLAGS, {27'h0, rflg[i]}, rrs_pkg::RESP_OKAY);
         exec(rop[i]);
         pc_exp = pc_exp + 15'h1;
         r9 = rot(rop[i][10], rdat[i], rflg[i][0]);
         rd_chk(rrs_pkg::OFF_ACC, {24'h0, rop[i][9] ? 8'h33 : r9[7:0]});
         rd_chk(rrs_pkg::OFF_FDATA, {24'h0, rop[i][9] ? r9[7:0] : rdat[i]});
         rd_chk(rrs_pkg::OFF_FLAGS, {27'h0, rflg[i][4:1], r9[8]});
         rd_chk(rrs_pkg::OFF_PC, {17'h0, pc_exp});
      end
      // Sleep on a dirty watchdog and mixed flags
      axi_wr(rrs_pkg::OFF_WDT, 32'habcd, rrs_pkg::RESP_OKAY);
      axi_wr(rrs_pkg::OFF_FLAGS, 32'h0f, rrs_pkg::RESP_OKAY);
      exec(rrs_pkg::OPC_SLEEP);
      rd_chk(rrs_pkg::OFF_WDT, 32'h0);
      rd_chk(rrs_pkg::OFF_FLAGS, 32'h17);
      rd_chk(rrs_pkg::OFF_ACC, 32'h33);
      // Subtract at the carry and nibble boundaries
      for (int i = 0; i < 6; i++) begin
         axi_wr(rrs_pkg::OFF_ACC, {24'h0, sacc[i]}, rrs_pkg::RESP_OKAY);
         axi_wr(rrs_pkg::OFF_FLAGS, 32'h10, rrs_pkg::RESP_OKAY);
         exec({8'h0d, slit[i]});
         rd_chk(rrs_pkg::OFF_ACC, {24'h0, slit[i] - sacc[i]});
         rd_chk(rrs_pkg::OFF_FLAGS, sub_flags(sacc[i], slit[i]));
      end
      // Unmapped places answer with a decode error
      axi_rd(8'h28, rd, rr);
      chk(rd, 32'h0);
      chk({30'h0, rr}, {30'h0, rrs_pkg::RESP_DECERR});
      axi_wr(8'h3c, 32'h5555, rrs_pkg::RESP_DECERR);
      stop_test;
   end

endmodule // rrs_exec_bench
